// *** design/cbt_cfg.svh ***
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

// register offsets, byte addresses
`define CBT_OFF_CFG      8'h00
`define CBT_OFF_FLAGS    8'h04
`define CBT_OFF_MASK     8'h08
`define CBT_OFF_CTRL     8'h0C

// bit timing register fields
`define CBT_BRP_LSB      0
`define CBT_SJW_LSB      6
`define CBT_PROP_LSB     8
`define CBT_PH1_LSB      11
`define CBT_SAM3_BIT     14
`define CBT_PH2FREE_BIT  15
`define CBT_PH2_LSB      16
`define CBT_CFG_MASK     32'h0007_FFFF
`define CBT_CFG_RST      32'h0000_0000

// interrupt flag positions
`define CBT_F_WAKE       14
`define CBT_F_BUSERR     13
`define CBT_F_SYSERR     12
`define CBT_F_RXOVF      11
`define CBT_F_MODE       3
`define CBT_F_TIMER      2
`define CBT_F_RX         1
`define CBT_F_TX         0
`define CBT_FLAG_MASK    32'h0000_780F

// control register fields
`define CBT_ON_BIT       15
`define CBT_REQ_LSB      24
`define CBT_CUR_LSB      21

// operating mode codes
`define CBT_MODE_NORMAL  3'h0
`define CBT_MODE_DISABLE 3'h1
`define CBT_MODE_CONFIG  3'h4

// prescaler: quantum is this many clocks per step of the field
`define CBT_TQ_CLK_MUL   2

`endif

// *** design/cbt_pkg.sv ***
package cbt_pkg;
  typedef logic [31:0] cbt_word_t;
  typedef logic [2:0]  cbt_mode_t;
  typedef logic [5:0]  cbt_brp_t;
  typedef logic [2:0]  cbt_seg_t;
endpackage : cbt_pkg

// *** design/cbt_tq_gen.sv ***
`timescale 1ns/1ps
`include "cbt_cfg.svh"

// quantum prescaler and bit segment sequencer
module cbt_tq_gen
(
  input  wire logic             sys_clk,    // system clock
  input  wire logic             reset_n,    // async reset, active low
  input  wire logic             run,        // count while high
  input  wire cbt_pkg::cbt_brp_t quantum_prescaler,       // quantum prescaler code
  input  wire cbt_pkg::cbt_seg_t prop,      // propagation segment code
  input  wire cbt_pkg::cbt_seg_t ph1,       // phase one code
  input  wire cbt_pkg::cbt_seg_t ph2,       // effective phase two code
  output logic                  tq_tick_r,  // one pulse per time quantum
  output logic                  sample_r,   // pulse at the sample point
  output logic                  bit_end_r   // pulse at the last quantum of a bit
);
  logic [6:0] pre_cnt_r;
  logic [6:0] pre_lim;
  logic [4:0] tq_idx_r;
  logic [4:0] smp_idx;
  logic [4:0] end_idx;
  logic       tick;

  // 2*(n+1) clocks per quantum
  assign pre_lim = 7'(`CBT_TQ_CLK_MUL * (int'(quantum_prescaler) + 1) - 1);
  assign tick    = run && (pre_cnt_r == pre_lim);
  // sync quantum, then prop+1, ph1+1, ph2+1 quanta
  assign smp_idx = 5'(int'(prop) + int'(ph1) + 2);
  assign end_idx = 5'(int'(prop) + int'(ph1) + int'(ph2) + 3);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_cnt_r <= 7'h00;
    else if (!run || tick)
      pre_cnt_r <= 7'h00;
    else
      pre_cnt_r <= pre_cnt_r + 7'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tq_idx_r <= 5'h00;
    else if (!run)
      tq_idx_r <= 5'h00;
    else if (tick)
      tq_idx_r <= (tq_idx_r >= end_idx) ? 5'h00 : tq_idx_r + 5'h01;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tq_tick_r <= 1'b0;
      sample_r  <= 1'b0;
      bit_end_r <= 1'b0;
    end
    else
    begin
      tq_tick_r <= tick;
      sample_r  <= tick && (tq_idx_r == smp_idx);
      bit_end_r <= tick && (tq_idx_r == end_idx);
    end
  end

  // helper: clocks since last quantum tick
  logic [7:0] gap_r;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      gap_r <= 8'h00;
    else if (!run || tick)
      gap_r <= 8'h00;
    else
      gap_r <= gap_r + 8'h01;
  end

  chk_quantum_period: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (tick && $stable(quantum_prescaler)) |-> (gap_r == 8'(`CBT_TQ_CLK_MUL * (int'(quantum_prescaler) + 1) - 1)))
    else $error("quantum period differs from prescaler setting");

  chk_prop_sample: assert property (@(posedge sys_clk) disable iff (!reset_n)
    sample_r |-> $past(tq_idx_r) == 5'(int'(prop) + int'(ph1) + 2))
    else $error("sample point not after prop and phase one");
endmodule : cbt_tq_gen

// *** design/cbt_top.sv ***
`timescale 1ns/1ps
`include "cbt_cfg.svh"

module cbt_top
#(
  parameter int TS_W = 16                          // timestamp counter width
)
(
  input  wire logic            sys_clk,            // system clock, 40 MHz
  input  wire logic            reset_n,            // async reset, active low
  input  wire logic [7:0]      reg_addr,           // register byte address
  input  wire logic [31:0]     reg_wdata,          // write data
  input  wire logic            reg_wr,             // write strobe
  input  wire logic            reg_rd,             // read strobe
  output cbt_pkg::cbt_word_t   reg_rdata_r,        // read data, cycle after strobe
  input  wire logic            can_rx,             // bus receive pin
  input  wire logic            bus_error_evt,      // protocol error pulse
  input  wire logic            sys_fault_evt,      // system bus access fault pulse
  input  wire logic            rx_no_buf_evt,      // message found no free buffer
  input  wire logic            rx_pending,         // receive buffer condition level
  input  wire logic            tx_pending,         // transmit buffer condition level
  output logic                 irq_r,              // level interrupt
  output cbt_pkg::cbt_mode_t   cur_mode_r,         // current operating mode
  output logic                 tq_tick_r,          // quantum tick
  output logic                 sample_r,           // sample point pulse
  output logic                 bit_end_r,          // end of bit pulse
  output logic                 sample3_r,          // three-sample mode selected
  output logic [1:0]           sjw_eff_r,          // effective jump width code
  output logic [4:0]           quanta_per_bit_r    // quanta in one bit
);
  cbt_pkg::cbt_word_t cfg_r;
  cbt_pkg::cbt_word_t flags_r;
  cbt_pkg::cbt_word_t flags_nxt;
  cbt_pkg::cbt_word_t mask_r;
  cbt_pkg::cbt_mode_t req_mode_r;
  logic               on_r;
  logic               on_rise;
  logic [TS_W-1:0]    ts_r;
  logic               rx_s1_r;
  logic               rx_s2_r;
  logic               rx_s3_r;
  logic               wake_evt;
  logic               mode_evt;
  logic               wrap_evt;
  logic               run;
  logic               wr_cfg;
  logic               wr_flags;
  logic               wr_mask;
  logic               wr_ctrl;
  cbt_pkg::cbt_word_t set_v;
  cbt_pkg::cbt_word_t clr_v;
  cbt_pkg::cbt_brp_t  quantum_prescaler;
  cbt_pkg::cbt_seg_t  prop;
  cbt_pkg::cbt_seg_t  ph1;
  cbt_pkg::cbt_seg_t  ph2_prog;
  cbt_pkg::cbt_seg_t  ph2_eff;
  logic [1:0]         resync_jump_width;
  logic               tick_w;

  assign wr_cfg   = reg_wr && (reg_addr == `CBT_OFF_CFG);
  assign wr_flags = reg_wr && (reg_addr == `CBT_OFF_FLAGS);
  assign wr_mask  = reg_wr && (reg_addr == `CBT_OFF_MASK);
  assign wr_ctrl  = reg_wr && (reg_addr == `CBT_OFF_CTRL);

  assign quantum_prescaler      = cfg_r[`CBT_BRP_LSB +: 6];
  assign resync_jump_width      = cfg_r[`CBT_SJW_LSB +: 2];
  assign prop     = cfg_r[`CBT_PROP_LSB +: 3];
  assign ph1      = cfg_r[`CBT_PH1_LSB +: 3];
  assign ph2_prog = cfg_r[`CBT_PH2_LSB +: 3];
  // phase two follows phase one unless freely programmed
  assign ph2_eff  = cfg_r[`CBT_PH2FREE_BIT] ? ph2_prog : ph1;

  // bit timing register, locked outside configuration mode
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_r <= `CBT_CFG_RST;
    else if (wr_cfg && cur_mode_r == `CBT_MODE_CONFIG)
      cfg_r <= reg_wdata & `CBT_CFG_MASK;
  end

  // control: module on and requested mode
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      on_r       <= 1'b0;
      req_mode_r <= `CBT_MODE_CONFIG;
    end
    else if (wr_ctrl)
    begin
      on_r       <= reg_wdata[`CBT_ON_BIT];
      req_mode_r <= reg_wdata[`CBT_REQ_LSB +: 3];
    end
  end

  assign on_rise  = wr_ctrl && !on_r && reg_wdata[`CBT_ON_BIT];
  assign mode_evt = (cur_mode_r != req_mode_r);

  // current mode tracks the request one clock later
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cur_mode_r <= `CBT_MODE_CONFIG;
    else
      cur_mode_r <= req_mode_r;
  end

  assign run = on_r && (cur_mode_r != `CBT_MODE_CONFIG)
                    && (cur_mode_r != `CBT_MODE_DISABLE);

  cbt_tq_gen u_tq
  (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .run       (run),
    .quantum_prescaler       (quantum_prescaler),
    .prop      (prop),
    .ph1       (ph1),
    .ph2       (ph2_eff),
    .tq_tick_r (tick_w),
    .sample_r  (sample_r),
    .bit_end_r (bit_end_r)
  );

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tq_tick_r <= 1'b0;
    else
      tq_tick_r <= tick_w;
  end

  // derived timing values
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sjw_eff_r        <= 2'h0;
      sample3_r        <= 1'b0;
      quanta_per_bit_r <= 5'h04;
    end
    else
    begin
      sjw_eff_r        <= (resync_jump_width > ph2_eff[1:0] && ph2_eff < 3'h4) ?
                          ph2_eff[1:0] : resync_jump_width;
      sample3_r        <= cfg_r[`CBT_SAM3_BIT];
      quanta_per_bit_r <= 5'(int'(prop) + int'(ph1) + int'(ph2_eff) + 4);
    end
  end

  // free-running timestamp, one count per quantum
  assign wrap_evt = tick_w && (&ts_r);
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ts_r <= '0;
    else if (tick_w)
      ts_r <= ts_r + 1'b1;
  end

  // receive pin synchroniser and wake edge detect
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= can_rx;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
    end
  end

  // dominant edge while disabled counts as bus activity
  assign wake_evt = rx_s3_r && !rx_s2_r && (cur_mode_r == `CBT_MODE_DISABLE);

  always_comb
  begin
    set_v                = '0;
    set_v[`CBT_F_WAKE]   = wake_evt;
    set_v[`CBT_F_BUSERR] = bus_error_evt;
    set_v[`CBT_F_SYSERR] = sys_fault_evt;
    set_v[`CBT_F_RXOVF]  = rx_no_buf_evt;
    set_v[`CBT_F_MODE]   = mode_evt;
    set_v[`CBT_F_TIMER]  = wrap_evt;
    clr_v                = wr_flags ? reg_wdata : '0;
    clr_v[`CBT_F_SYSERR] = on_rise;
    clr_v[`CBT_F_RX]     = 1'b0;
    clr_v[`CBT_F_TX]     = 1'b0;
    // set wins over a clear in the same cycle
    flags_nxt            = ((flags_r & ~clr_v) | set_v) & `CBT_FLAG_MASK;
    flags_nxt[`CBT_F_RX] = rx_pending;
    flags_nxt[`CBT_F_TX] = tx_pending;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      flags_r <= '0;
    else
      flags_r <= flags_nxt;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      mask_r <= '0;
    else if (wr_mask)
      mask_r <= reg_wdata & `CBT_FLAG_MASK;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(flags_nxt & mask_r);
  end

  // read port, data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata_r <= '0;
    else if (!reg_rd)
      reg_rdata_r <= '0;
    else
    begin
      unique case (reg_addr)
        `CBT_OFF_CFG:   reg_rdata_r <= cfg_r;
        `CBT_OFF_FLAGS: reg_rdata_r <= flags_r;
        `CBT_OFF_MASK:  reg_rdata_r <= mask_r;
        `CBT_OFF_CTRL:  reg_rdata_r <= (32'(req_mode_r) << `CBT_REQ_LSB)
                                     | (32'(cur_mode_r) << `CBT_CUR_LSB)
                                     | (32'(on_r) << `CBT_ON_BIT);
        default:        reg_rdata_r <= '0;
      endcase
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_locked_write;
    wr_cfg && cur_mode_r != `CBT_MODE_CONFIG;
  endsequence

  sequence s_flag_write_one(int b);
    wr_flags && reg_wdata[b];
  endsequence

  chk_cfg_lock: assert property (s_locked_write |=> $stable(cfg_r))
    else $error("timing register changed outside configuration mode");

  chk_ph2_auto: assert property (!cfg_r[`CBT_PH2FREE_BIT] |-> ph2_eff == ph1)
    else $error("phase two not derived from phase one");

  chk_sjw_bound: assert property ($stable(cfg_r) |->
    (ph2_eff >= 3'h4) || (sjw_eff_r <= ph2_eff[1:0]))
    else $error("jump width exceeds phase two");

  chk_wake_set: assert property (wake_evt |=> flags_r[`CBT_F_WAKE])
    else $error("wake flag not set");

  chk_buserr_set: assert property (bus_error_evt |=> flags_r[`CBT_F_BUSERR])
    else $error("bus error flag not set");

  chk_syserr_set: assert property (sys_fault_evt |=> flags_r[`CBT_F_SYSERR])
    else $error("system error flag not set");

  chk_syserr_hold: assert property ((s_flag_write_one(`CBT_F_SYSERR) ##0
    flags_r[`CBT_F_SYSERR] && !on_rise) |=> flags_r[`CBT_F_SYSERR])
    else $error("system error flag cleared by write");

  chk_rxovf_set: assert property (rx_no_buf_evt |=> flags_r[`CBT_F_RXOVF])
    else $error("overflow flag not set");

  chk_mode_flag: assert property (mode_evt |=>
    flags_r[`CBT_F_MODE] && cur_mode_r == $past(req_mode_r))
    else $error("mode change not reported");

  chk_timer_wrap: assert property (wrap_evt |=> flags_r[`CBT_F_TIMER] && ts_r == '0)
    else $error("timestamp wrap not reported");

  chk_rx_follow: assert property (##1 flags_r[`CBT_F_RX] == $past(rx_pending))
    else $error("receive flag does not follow source");

  chk_tx_follow: assert property (##1 flags_r[`CBT_F_TX] == $past(tx_pending))
    else $error("transmit flag does not follow source");

  chk_sticky_hold: assert property ((flags_r[`CBT_F_BUSERR] && !wr_flags)
    |=> flags_r[`CBT_F_BUSERR])
    else $error("event flag dropped without clear");

  chk_irq_level: assert property (##1 irq_r == $past(|(flags_nxt & mask_r)))
    else $error("interrupt level wrong");
endmodule : cbt_top

// *** verification/cbt_can_node.sv ***
`timescale 1ns/1ps

// recessive-idle bus node, sends a short dominant burst on request
module cbt_can_node
(
  input  wire logic sys_clk,   // system clock
  input  wire logic reset_n,   // async reset, active low
  input  wire logic wake_req,  // start a dominant burst
  output logic      can_rx     // bus level seen by the controller
);
  logic [3:0] cnt_r;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_r <= 4'h0;
    else if (wake_req)
      cnt_r <= 4'hC;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end

  // bus floats recessive between bursts
  assign can_rx = (cnt_r == 4'h0);
endmodule : cbt_can_node

// *** verification/cbt_top_test.sv ***
`timescale 1ns/1ps
`include "cbt_cfg.svh"

module cbt_top_test;
  logic               sys_clk, reset_n, reg_wr, reg_rd, wake_req, can_rx;
  logic               bus_error_evt, sys_fault_evt, rx_no_buf_evt, rx_pending, tx_pending;
  logic [7:0]         reg_addr;
  logic [31:0]        reg_wdata, d, cfg;
  cbt_pkg::cbt_word_t reg_rdata_r;
  cbt_pkg::cbt_mode_t cur_mode_r;
  logic               irq_r, tq_tick_r, sample_r, bit_end_r, sample3_r;
  logic [1:0]         sjw_eff_r;
  logic [4:0]         quanta_per_bit_r;
  int                 err_count, cmp_count, seed, n, m;
  logic [31:0]        tbl [4] = '{32'h0001_9800, 32'h0000_2701, 32'h0002_D23F, 32'h0000_3BC5};

  cbt_top #(.TS_W(4)) dut (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_r, .can_rx, .bus_error_evt, .sys_fault_evt, .rx_no_buf_evt, .rx_pending,
    .tx_pending, .irq_r, .cur_mode_r, .tq_tick_r, .sample_r, .bit_end_r, .sample3_r,
    .sjw_eff_r, .quanta_per_bit_r);

  cbt_can_node node (.sys_clk, .reset_n, .wake_req, .can_rx);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata_r;
  endtask : rd

  task automatic pulse(input int w);
    @(posedge sys_clk);
    bus_error_evt <= (w == 0);
    sys_fault_evt <= (w == 1);
    rx_no_buf_evt <= (w == 2);
    @(posedge sys_clk);
    bus_error_evt <= 1'b0;
    sys_fault_evt <= 1'b0;
    rx_no_buf_evt <= 1'b0;
  endtask : pulse

  // clocks until the chosen pulse is seen, bounded
  task automatic waitp(input int sel, output int k);
    k = 0;
    do
    begin
      @(posedge sys_clk);
      #1 k++;
    end
    while (!(sel == 0 ? bit_end_r : sel == 1 ? sample_r : tq_tick_r) && k < 5000);
  endtask : waitp

  function automatic int ph2e(input logic [31:0] c);
    return c[15] ? c[18:16] : c[13:11];
  endfunction : ph2e

  function automatic int qpb(input logic [31:0] c);
    return c[10:8] + c[13:11] + ph2e(c) + 4;
  endfunction : qpb

  // keep random settings inside the software duties
  function automatic logic [31:0] fix(input logic [31:0] r);
    logic [31:0] c;
    c = r & `CBT_CFG_MASK;
    if (c[18:16] > c[13:11]) c[18:16] = c[13:11];
    if (c[7:6] > ph2e(c)) c[7:6] = 2'(ph2e(c));
    if (c[5:0] < 6'h02) c[14] = 1'b0;
    if (qpb(c) <= 7) c[10:8] = 3'h7;
    return c;
  endfunction : fix

  task automatic meas(input logic [31:0] c);
    wr(`CBT_OFF_CTRL, 32'h0400_8000);
    repeat (3) @(posedge sys_clk);
    wr(`CBT_OFF_CFG, c);
    wr(`CBT_OFF_CTRL, 32'h0000_8000);
    waitp(2, n);
    waitp(2, n);
    chk("quantum clocks", 2 * (c[5:0] + 1), n);
    waitp(0, n);
    waitp(0, n);
    chk("bit clocks", 2 * (c[5:0] + 1) * qpb(c), n);
    waitp(1, n);
    waitp(0, m);
    chk("sample to end", 2 * (c[5:0] + 1) * (ph2e(c) + 1), m);
  endtask : meas

  task automatic summarize;
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  initial
  begin
    #(25ns * 80000);
    err_count++;
    summarize;
  end

  initial
  begin
    seed = 32'he2863f45;
    {reset_n, reg_wr, reg_rd, wake_req, bus_error_evt, sys_fault_evt} = '0;
    {rx_no_buf_evt, rx_pending, tx_pending} = '0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`CBT_OFF_CFG, d);
    chk("cfg reset", `CBT_CFG_RST, d);
    rd(`CBT_OFF_CTRL, d);
    chk("ctrl reset", 32'h0480_0000, d);
    rd(`CBT_OFF_FLAGS, d);
    chk("flags reset", 32'h0000_0000, d);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, d);
    chk("unmapped", 32'h0000_0000, d);
    repeat (6)
    begin
      cfg = fix($random(seed));
      wr(`CBT_OFF_CFG, cfg);
      rd(`CBT_OFF_CFG, d);
      chk("cfg readback", cfg, d);
      repeat (2) @(posedge sys_clk);
      #1 chk("quanta per bit", qpb(cfg), quanta_per_bit_r);
      chk("jump width", cfg[7:6], sjw_eff_r);
      chk("sample3", cfg[14], sample3_r);
    end
    foreach (tbl[i])
      meas(tbl[i]);
    rd(`CBT_OFF_CTRL, d);
    chk("ctrl normal", 32'h0000_8000, d);
    chk("cur mode", `CBT_MODE_NORMAL, cur_mode_r);
    rd(`CBT_OFF_FLAGS, d);
    chk("mode flag", 1, d[3]);
    chk("timer flag", 1, d[2]);
    wr(`CBT_OFF_CFG, 32'h0000_0000);
    rd(`CBT_OFF_CFG, d);
    chk("cfg locked", tbl[3], d);
    wr(`CBT_OFF_FLAGS, 32'h0000_0008);
    rd(`CBT_OFF_FLAGS, d);
    chk("mode clear", 0, d[3]);
    wr(`CBT_OFF_MASK, 32'h0000_2000);
    pulse(0);
    @(posedge sys_clk);
    #1 chk("irq bus error", 1, irq_r);
    pulse(1);
    pulse(2);
    rd(`CBT_OFF_FLAGS, d);
    chk("event flags", 32'h0000_3800, d & 32'h0000_3800);
    wr(`CBT_OFF_FLAGS, 32'h0000_3800);
    rd(`CBT_OFF_FLAGS, d);
    chk("write clear", 32'h0000_1000, d & 32'h0000_3800);
    chk("irq masked", 0, irq_r);
    wr(`CBT_OFF_MASK, 32'h0000_1000);
    @(posedge sys_clk);
    #1 chk("irq sys error", 1, irq_r);
    wr(`CBT_OFF_CTRL, 32'h0000_0000);
    wr(`CBT_OFF_CTRL, 32'h0000_8000);
    rd(`CBT_OFF_FLAGS, d);
    chk("sys clear", 0, d[12]);
    chk("irq cleared", 0, irq_r);
    wr(`CBT_OFF_MASK, 32'h0000_0000);
    repeat (6)
    begin
      @(posedge sys_clk);
      rx_pending <= 1'($random(seed));
      tx_pending <= 1'($random(seed));
      wr(`CBT_OFF_FLAGS, 32'h0000_0003);
      rd(`CBT_OFF_FLAGS, d);
      chk("pending", {rx_pending, tx_pending}, d[1:0]);
    end
    wr(`CBT_OFF_CTRL, 32'h0100_8000);
    repeat (3) @(posedge sys_clk);
    wr(`CBT_OFF_FLAGS, 32'h0000_4008);
    rd(`CBT_OFF_FLAGS, d);
    chk("wake idle", 0, d[14]);
    @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(`CBT_OFF_FLAGS, d);
    chk("wake flag", 1, d[14]);
    summarize;
  end
endmodule : cbt_top_test
